// ### rtl/fuar_consts.svh
`ifndef FUAR_CONSTS_SVH
`define FUAR_CONSTS_SVH
`define FUAR_KEY_OFFSET 32'h0000_0000
`define FUAR_ADDR_OFFSET 32'h0000_0004
`define FUAR_OP_OFFSET 32'h0000_0008
`define FUAR_EFF_OFFSET 32'h0000_000c
`define FUAR_KEY_RESET 32'h0000_0000
`define FUAR_ADDR_RESET 32'h0000_0000
`define FUAR_OP_RESET 4'h0
`define FUAR_EFF_RESET 32'h0000_0000
`define FUAR_READY_RESET 1'b1
`define FUAR_PAGE_MASK 32'hffff_f800
`define FUAR_ROW_MASK 32'hffff_ff00
`define FUAR_DWORD_MASK 32'hffff_fffc
`define FUAR_OP_DWORD 4'h2
`define FUAR_OP_ROW 4'h3
`define FUAR_OP_PAGE 4'h4
`define FUAR_RESP_OKAY 2'h0
`define FUAR_RESP_SLVERR 2'h2
`endif

// ### rtl/fuar_pkg.sv
package fuar_pkg;
	typedef struct packed {
		logic [3:0] op;
		logic [31:0] addr;
	} fuar_target_t;
endpackage

// ### rtl/fuar_regs.sv
`include "fuar_consts.svh"
// How it works
// RULE1: unlock key is write-only; every read of it returns zero.
// RULE2: unlock key is 32 bits, cleared to zero at reset.
// RULE3: target address is 32-bit read/write, cleared to zero at reset.
// RULE4: page erase ignores address bits ten down to zero.
// RULE5: row program ignores address bits seven down to zero.
// RULE6: double-word program targets 32-bit unit, ignores address bits one and zero.
module fuar_regs import fuar_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] unlock_key,
	output logic key_written,
	output fuar_target_t target
);
	// ------------------------------------------------
	// write channel
	// ------------------------------------------------
	logic aw_held_q;
	logic w_held_q;
	logic [31:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [31:0] key_q;
	logic [31:0] addr_q;
	logic [3:0] op_q;
	logic key_wr_q;
	logic [31:0] eff_q;
	logic [31:0] eff_d;
	logic do_wr;
	logic [31:0] wmask;
	logic wr_hit;
	logic aw_held_d;
	logic w_held_d;
	logic bvalid_d;
	logic awready_q;
	logic wready_q;
	logic rvalid_d;
	logic arready_q;

	assign do_wr = aw_held_q && w_held_q && !s_axi_bvalid;
	assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign wr_hit = awaddr_q == `FUAR_KEY_OFFSET || awaddr_q == `FUAR_ADDR_OFFSET ||
		awaddr_q == `FUAR_OP_OFFSET || awaddr_q == `FUAR_EFF_OFFSET;
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;

	// next handshake state, so the readies can come from flip-flops
	always_comb begin
		aw_held_d = aw_held_q;
		w_held_d = w_held_q;
		bvalid_d = s_axi_bvalid;
		if (s_axi_awvalid && awready_q) begin
			aw_held_d = 1'b1;
		end else if (do_wr) begin
			aw_held_d = 1'b0;
		end
		if (s_axi_wvalid && wready_q) begin
			w_held_d = 1'b1;
		end else if (do_wr) begin
			w_held_d = 1'b0;
		end
		if (do_wr) begin
			bvalid_d = 1'b1;
		end else if (s_axi_bready) begin
			bvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 32'h0000_0000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			if (s_axi_awvalid && awready_q) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_q) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= `FUAR_READY_RESET;
			wready_q <= `FUAR_READY_RESET;
		end else begin
			awready_q <= !aw_held_d && !bvalid_d;
			wready_q <= !w_held_d && !bvalid_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `FUAR_RESP_OKAY;
		end else begin
			s_axi_bvalid <= bvalid_d;
			if (do_wr) begin
				s_axi_bresp <= wr_hit ? `FUAR_RESP_OKAY : `FUAR_RESP_SLVERR;
			end
		end
	end

	// ------------------------------------------------
	// registers
	// ------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			key_q <= `FUAR_KEY_RESET; // RULE2
			key_wr_q <= 1'b0;
		end else begin
			key_wr_q <= do_wr && awaddr_q == `FUAR_KEY_OFFSET;
			if (do_wr && awaddr_q == `FUAR_KEY_OFFSET) begin
				key_q <= (key_q & ~wmask) | (wdata_q & wmask); // RULE2
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_q <= `FUAR_ADDR_RESET; // RULE3
			op_q <= `FUAR_OP_RESET;
		end else if (do_wr) begin
			if (awaddr_q == `FUAR_ADDR_OFFSET) begin
				addr_q <= (addr_q & ~wmask) | (wdata_q & wmask); // RULE3
			end
			if (awaddr_q == `FUAR_OP_OFFSET && wstrb_q[0]) begin
				op_q <= wdata_q[3:0];
			end
		end
	end

	// ------------------------------------------------
	// effective address per operation
	// ------------------------------------------------
	always_comb begin
		unique case (op_q)
			`FUAR_OP_PAGE: eff_d = addr_q & `FUAR_PAGE_MASK; // RULE4
			`FUAR_OP_ROW: eff_d = addr_q & `FUAR_ROW_MASK; // RULE5
			`FUAR_OP_DWORD: eff_d = addr_q & `FUAR_DWORD_MASK; // RULE6
			default: eff_d = addr_q;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eff_q <= `FUAR_EFF_RESET;
		end else begin
			eff_q <= eff_d;
		end
	end

	assign unlock_key = key_q;
	assign key_written = key_wr_q;
	assign target.op = op_q;
	assign target.addr = eff_q;

	// ------------------------------------------------
	// read channel
	// ------------------------------------------------
	assign s_axi_arready = arready_q;

	always_comb begin
		rvalid_d = s_axi_rvalid;
		if (s_axi_arvalid && arready_q) begin
			rvalid_d = 1'b1;
		end else if (s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= `FUAR_READY_RESET;
		end else begin
			arready_q <= !rvalid_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `FUAR_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `FUAR_RESP_OKAY;
			unique case (s_axi_araddr)
				`FUAR_KEY_OFFSET: s_axi_rdata <= 32'h0000_0000; // RULE1
				`FUAR_ADDR_OFFSET: s_axi_rdata <= addr_q; // RULE3
				`FUAR_OP_OFFSET: s_axi_rdata <= {28'h000_0000, op_q};
				`FUAR_EFF_OFFSET: s_axi_rdata <= eff_q;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `FUAR_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------
	// checks
	// ------------------------------------------------
	chk_key_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == `FUAR_KEY_OFFSET)
		|=> s_axi_rdata == 32'h0000_0000)
		else $error("key read not zero");
	chk_key_reset: assert property (@(posedge aclk) // RULE2
		!aresetn |=> key_q == 32'h0000_0000)
		else $error("key not cleared");
	chk_key_store: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
		(do_wr && awaddr_q == `FUAR_KEY_OFFSET && wstrb_q == 4'hf)
		|=> key_q == $past(wdata_q) && key_written)
		else $error("key not stored");
	sequence seq_addr_commit;
		do_wr && awaddr_q == `FUAR_ADDR_OFFSET && wstrb_q == 4'hf;
	endsequence
	sequence seq_unmapped_commit;
		do_wr && !wr_hit;
	endsequence
	chk_addr_readback: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
		seq_addr_commit |=> addr_q == $past(wdata_q))
		else $error("address not stored");
	chk_unmapped_ignored: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
		seq_unmapped_commit |=> $stable(addr_q) && $stable(key_q) && $stable(op_q) &&
		s_axi_bresp == `FUAR_RESP_SLVERR)
		else $error("unmapped write changed state");
	chk_addr_reset: assert property (@(posedge aclk) // RULE3
		!aresetn |=> addr_q == 32'h0000_0000)
		else $error("address not cleared");
	chk_page_mask: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
		op_q == `FUAR_OP_PAGE |=> target.addr[10:0] == 11'h000 ||
		$past(op_q) != `FUAR_OP_PAGE)
		else $error("page bits not ignored");
	chk_row_mask: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
		op_q == `FUAR_OP_ROW && $stable(op_q) |=> target.addr[7:0] == 8'h00)
		else $error("row bits not ignored");
	chk_dword_mask: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
		op_q == `FUAR_OP_DWORD |=> target.addr == ($past(addr_q) & `FUAR_DWORD_MASK))
		else $error("dword bits not ignored");
endmodule

// ### tb/flash_unlock_and_address_regs_tb.sv
`include "fuar_consts.svh"
module flash_unlock_and_address_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fuar_pkg::*;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic awr, wrd, bv, arr, rv, kw;
	logic [31:0] awa = 0, wd = 0, ara = 0, rd, key, v, a, q;
	logic [1:0] br, rr, r;
	logic [3:0] ws = 4'hf;
	fuar_target_t tgt;
	int err_total = 0, n_tests = 0, kw_n = 0;
	logic [3:0] ops[$] = '{`FUAR_OP_DWORD, `FUAR_OP_ROW, `FUAR_OP_PAGE, 4'h0};
	fuar_regs i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .unlock_key(key),
		.key_written(kw), .target(tgt));
	initial forever #2 aclk = ~aclk;
	always @(posedge aclk) if (kw === 1'b1) kw_n++;
	// ----------------
	// bus and check tasks
	// ----------------
	task automatic chk(input string s, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [31:0] ad, d, output logic [1:0] rs);
		@(posedge aclk);
		awa <= ad;
		wd <= d;
		awv <= 1;
		wv <= 1;
		bry <= 1;
		do begin
			@(posedge aclk);
			if (awr) awv <= 0;
			if (wrd) wv <= 0;
		end while (bv !== 1'b1);
		bry <= 0;
		rs = br;
	endtask
	task automatic rdt(input logic [31:0] ad, output logic [31:0] d, output logic [1:0] rs);
		@(posedge aclk);
		ara <= ad;
		arv <= 1;
		rry <= 1;
		do begin
			@(posedge aclk);
			if (arr) arv <= 0;
		end while (rv !== 1'b1);
		rry <= 0;
		d = rd;
		rs = rr;
	endtask
	// expected target address for an operation
	function automatic logic [31:0] msk(input logic [3:0] o, input logic [31:0] x);
		case (o)
			`FUAR_OP_PAGE: return x & ~32'h7ff;
			`FUAR_OP_ROW: return x & ~32'hff;
			`FUAR_OP_DWORD: return x & ~32'h3;
			default: return x;
		endcase
	endfunction
	task automatic end_sim;
		if (err_total == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----------------
	// tests
	// ----------------
	initial begin
		void'($urandom(32'hc9f5));
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		chk("key out", 0, key);
		rdt(`FUAR_ADDR_OFFSET, q, r);
		chk("addr rst", 0, q);
		chk("tgt rst", 0, tgt.addr);
		foreach (ops[i]) begin
			v = $urandom;
			a = $urandom;
			wr(`FUAR_KEY_OFFSET, v, r);
			wr(`FUAR_OP_OFFSET, {28'h0, ops[i]}, r);
			wr(`FUAR_ADDR_OFFSET, a, r);
			chk("wr resp", {30'h0, `FUAR_RESP_OKAY}, {30'h0, r});
			repeat (2) @(posedge aclk);
			chk("key out", v, key);
			chk("key pulses", 32'(i + 1), 32'(kw_n));
			chk("tgt op", {28'h0, ops[i]}, {28'h0, tgt.op});
			chk("tgt addr", msk(ops[i], a), tgt.addr);
			rdt(`FUAR_KEY_OFFSET, q, r);
			chk("key read", 0, q);
			rdt(`FUAR_ADDR_OFFSET, q, r);
			chk("addr read", a, q);
			chk("rd resp", {30'h0, `FUAR_RESP_OKAY}, {30'h0, r});
			rdt(`FUAR_EFF_OFFSET, q, r);
			chk("eff addr", msk(ops[i], a), q);
		end
		ws <= 4'($urandom);
		v = $urandom;
		wr(`FUAR_ADDR_OFFSET, v, r);
		for (int b = 0; b < 4; b++) begin
			if (ws[b])
				a[8*b +: 8] = v[8*b +: 8];
		end
		rdt(`FUAR_ADDR_OFFSET, q, r);
		chk("strb addr", a, q);
		ws <= 4'hf;
		wr(32'h10, v, r);
		chk("bad wr resp", {30'h0, `FUAR_RESP_SLVERR}, {30'h0, r});
		rdt(`FUAR_ADDR_OFFSET, q, r);
		chk("addr kept", a, q);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("key rst2", 0, key);
		chk("tgt rst2", 0, tgt.addr);
		rdt(`FUAR_ADDR_OFFSET, q, r);
		chk("addr rst2", 0, q);
		rdt(32'h10, q, r);
		chk("bad resp", {30'h0, `FUAR_RESP_SLVERR}, {30'h0, r});
		chk("bad data", 0, q);
		end_sim;
	end
	initial begin
		repeat (2000) @(posedge aclk);
		err_total++;
		end_sim;
	end
endmodule
